// ==== src/tvc_ctrl_regs.sv ====
// Serial-bus write-only control register bank with decoded adjustment outputs.
// Function
// - Answer only write address 8AH
// - Upper nibble 0: pointer advances per byte
// - Upper nibble 8: same register every byte
// - Registers load documented power-on bytes
// - Adjustment codes pass through monotonically
// - Saturation zero turns colour fully off
// - Tint code 00 reddish, 3F greenish
// - Cut-off red, green, blue eight bits
// - Drive red, blue low seven bits
// - Tuning offset code, 00 may defeat
// - Defeat only with stage 0, code 00
// - Gain delay six-bit code passed out
// - Video level from 0B upper bits
// - Horizontal centre from 0B low bits
// - Carrier oscillator trim from 0C
// - 00-D7 selects colour standard, 0 PAL
// - Forced SECAM puts colour outputs high-Z
// - 01-D7 vertical auto or manual
// - 02-D7 forces 60 Hz only manual
// - 01-D6 inhibits vertical trigger input
// - 03-D7,0B-D7 choose sound route
// - 03-D6 selects video input
// - 08-D7 selects chroma oscillator
// - 0A-D7,D6 select status pin source
// - 07-D7,0B-D3 select sound carrier
`timescale 1ns/1ps
module tvc_ctrl_regs (
	input wire logic sys_clk_i, // 100 MHz system clock
	input wire logic rst_i, // Async reset, active high
	input wire logic scl_i, // Serial clock, sampled
	input wire logic sda_i, // Serial data level
	output logic sda_o, // Serial data drive value
	output logic sda_oe_o, // High while pulling data low
	output logic colour_std_o, // 0 PAL, 1 NTSC
	output logic forced_secam_select_o, // Forced SECAM mode
	output logic chroma_hiz_o, // Colour difference outputs high-Z
	output logic [5:0] saturation_o, // Colour saturation code
	output logic colour_off_o, // Chroma fully suppressed
	output logic [5:0] tint_o, // Tint code
	output logic vertical_manual_o, // Manual vertical frequency
	output logic vertical_trigger_inhibit_o, // Vertical trigger off
	output logic [6:0] brightness_o, // Brightness code
	output logic vertical_rate_force_o, // Stored 50/60 bit
	output logic vert_60hz_force_o, // Effective 60 Hz force
	output logic [5:0] contrast_o, // Contrast code
	output logic [1:0] sound_route_o, // {sound_route_bit_a, _b}
	output logic video_input_select_o, // 0 input 1, 1 input 2
	output logic [7:0] cutoff_r_o, // Red cut-off code
	output logic [7:0] cutoff_g_o, // Green cut-off code
	output logic [7:0] cutoff_b_o, // Blue cut-off code
	output logic [6:0] drive_r_o, // Red drive code
	output logic [6:0] drive_b_o, // Blue drive code
	output logic [1:0] sound_carrier_o, // {sound_carrier_bit_a, _b}
	output logic chroma_osc_select_o, // 0 4.43 MHz, 1 3.58 MHz
	output logic [7:0] tuning_offset_code_o, // Tuning offset code
	output logic tuning_range_stage_o, // 1 with offset
	output logic tuning_defeat_o, // Tuning output defeated
	output logic [5:0] gain_delay_code_o, // Gain-control delay code
	output logic [1:0] status_select_o, // Status pin source
	output logic [2:0] video_level_o, // Detection level code
	output logic [2:0] hpos_o, // Horizontal centre code
	output logic [6:0] carrier_osc_trim_code_o // Carrier oscillator trim
);

	// Current and next state of the whole block
	tvc_pkg::tvc_state_t st_reg;
	tvc_pkg::tvc_state_t st_next;
	// Bus edge and condition decodes
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	// True while the serial clock sits high across two samples
	function automatic logic scl_high(input logic prev, input logic now);
		scl_high = prev & now;
	endfunction

	// Defeat needs stage clear and code zero
	function automatic logic defeat_of(input logic [12:0][7:0] r);
		defeat_of = ~r[tvc_pkg::TVC_SUB_TRIM][tvc_pkg::TVC_BIT_D7] &&
			(r[tvc_pkg::TVC_SUB_TUNE] == 8'h00);
	endfunction

	// Edge and start/stop detection on the sampled pins
	always_comb begin
		scl_rise = scl_i & ~st_reg.scl_q;
		scl_fall = ~scl_i & st_reg.scl_q;
		bus_start = scl_high(st_reg.scl_q, scl_i) & st_reg.sda_q & ~sda_i;
		bus_stop = scl_high(st_reg.scl_q, scl_i) & ~st_reg.sda_q & sda_i;
	end

	// Serial engine and register writes
	always_comb begin
		st_next = st_reg;
		st_next.scl_q = scl_i;
		st_next.sda_q = sda_i;
		// Open-drain pin only ever pulls low, so the drive value stays 0
		st_next.sda_out = 1'b0;
		if (bus_start) begin
			// Repeated start also lands here
			st_next.fsm = tvc_pkg::TVC_ADDR;
			st_next.cnt = 4'h0;
			st_next.sda_oe = 1'b0;
		end else if (bus_stop) begin
			st_next.fsm = tvc_pkg::TVC_IDLE;
			st_next.sda_oe = 1'b0;
		end else begin
			case (st_reg.fsm)
				tvc_pkg::TVC_ADDR, tvc_pkg::TVC_SUB, tvc_pkg::TVC_DATA: begin
					// Data is taken on the rising clock
					if (scl_rise && st_reg.cnt < tvc_pkg::TVC_BYTE_BITS) begin
						st_next.shift = {st_reg.shift[6:0], sda_i};
						st_next.cnt = st_reg.cnt + 4'h1;
					end
					// Byte complete: act on the falling clock
					if (scl_fall && st_reg.cnt == tvc_pkg::TVC_BYTE_BITS) begin
						if (st_reg.fsm == tvc_pkg::TVC_ADDR) begin
							// Reads and other addresses are not answered
							if (st_reg.shift == tvc_pkg::TVC_SLAVE_WR) begin
								st_next.sda_oe = 1'b1;
								st_next.fsm = tvc_pkg::TVC_ACK_A;
							end else begin
								st_next.fsm = tvc_pkg::TVC_SKIP;
							end
						end else if (st_reg.fsm == tvc_pkg::TVC_SUB) begin
							// Only the two documented modes are acknowledged
							if (st_reg.shift[7:4] == tvc_pkg::TVC_MODE_INC ||
								st_reg.shift[7:4] == tvc_pkg::TVC_MODE_HOLD) begin
								st_next.ptr = st_reg.shift[3:0];
								st_next.auto_inc =
									(st_reg.shift[7:4] == tvc_pkg::TVC_MODE_INC);
								st_next.sda_oe = 1'b1;
								st_next.fsm = tvc_pkg::TVC_ACK_S;
							end else begin
								st_next.fsm = tvc_pkg::TVC_SKIP;
							end
						end else begin
							// Subaddresses above 0C store nothing
							if (st_reg.ptr <= tvc_pkg::TVC_SUB_LAST) begin
								st_next.regs[st_reg.ptr] = st_reg.shift;
							end
							// Pointer saturates so it never wraps onto 00
							if (st_reg.auto_inc && st_reg.ptr != 4'hf) begin
								st_next.ptr = st_reg.ptr + 4'h1;
							end
							st_next.sda_oe = 1'b1;
							st_next.fsm = tvc_pkg::TVC_ACK_D;
						end
					end
				end
				tvc_pkg::TVC_ACK_A, tvc_pkg::TVC_ACK_S, tvc_pkg::TVC_ACK_D: begin
					// Release acknowledge after its clock pulse
					if (scl_fall) begin
						st_next.sda_oe = 1'b0;
						st_next.cnt = 4'h0;
						if (st_reg.fsm == tvc_pkg::TVC_ACK_A) begin
							st_next.fsm = tvc_pkg::TVC_SUB;
						end else begin
							st_next.fsm = tvc_pkg::TVC_DATA;
						end
					end
				end
				tvc_pkg::TVC_IDLE, tvc_pkg::TVC_SKIP: begin
					// Wait for the next start condition
					st_next.sda_oe = 1'b0;
				end
				default: begin
					st_next.fsm = tvc_pkg::TVC_IDLE;
					st_next.sda_oe = 1'b0;
				end
			endcase
		end
		// Derived controls, registered so outputs come from flops
		st_next.colour_off = (st_next.regs[tvc_pkg::TVC_SUB_COLOUR][5:0] == 6'h00);
		st_next.chroma_hiz = st_next.regs[tvc_pkg::TVC_SUB_COLOUR][tvc_pkg::TVC_BIT_D6];
		st_next.tune_defeat = defeat_of(st_next.regs);
		// Rate bit only counts in manual mode
		st_next.vert_60hz = st_next.regs[tvc_pkg::TVC_SUB_TINT][tvc_pkg::TVC_BIT_D7] &
			st_next.regs[tvc_pkg::TVC_SUB_BRIGHT][tvc_pkg::TVC_BIT_D7];
	end

	// State register; power-on bytes come from the package
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg <= '0;
			st_reg.scl_q <= 1'b1;
			st_reg.sda_q <= 1'b1;
			st_reg.fsm <= tvc_pkg::TVC_IDLE;
			st_reg.regs <= tvc_pkg::TVC_RESET;
			st_reg.chroma_hiz <= 1'b0;
			st_reg.colour_off <= 1'b0;
			st_reg.tune_defeat <= 1'b0;
			st_reg.vert_60hz <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Pin outputs
	assign sda_o = st_reg.sda_out;
	assign sda_oe_o = st_reg.sda_oe;
	// Mode switches and codes straight from stored bits; high-Z, colour off and 60 Hz force from derived flops
	assign colour_std_o = st_reg.regs[tvc_pkg::TVC_SUB_COLOUR][tvc_pkg::TVC_BIT_D7];
	assign forced_secam_select_o = st_reg.regs[tvc_pkg::TVC_SUB_COLOUR][tvc_pkg::TVC_BIT_D6];
	assign chroma_hiz_o = st_reg.chroma_hiz;
	assign colour_off_o = st_reg.colour_off;
	assign saturation_o = st_reg.regs[tvc_pkg::TVC_SUB_COLOUR][tvc_pkg::TVC_MSB_6BIT:0];
	assign tint_o = st_reg.regs[tvc_pkg::TVC_SUB_TINT][tvc_pkg::TVC_MSB_6BIT:0];
	assign vertical_manual_o = st_reg.regs[tvc_pkg::TVC_SUB_TINT][tvc_pkg::TVC_BIT_D7];
	assign vertical_trigger_inhibit_o =
		st_reg.regs[tvc_pkg::TVC_SUB_TINT][tvc_pkg::TVC_BIT_D6];
	assign brightness_o = st_reg.regs[tvc_pkg::TVC_SUB_BRIGHT][tvc_pkg::TVC_MSB_7BIT:0];
	assign vertical_rate_force_o = st_reg.regs[tvc_pkg::TVC_SUB_BRIGHT][tvc_pkg::TVC_BIT_D7];
	assign vert_60hz_force_o = st_reg.vert_60hz;
	assign contrast_o = st_reg.regs[tvc_pkg::TVC_SUB_CONTRAST][tvc_pkg::TVC_MSB_6BIT:0];
	// Route pairs 03-D7 with 0B-D7
	assign sound_route_o = {st_reg.regs[tvc_pkg::TVC_SUB_CONTRAST][tvc_pkg::TVC_BIT_D7],
		st_reg.regs[tvc_pkg::TVC_SUB_VIDEO][tvc_pkg::TVC_BIT_D7]};
	assign video_input_select_o =
		st_reg.regs[tvc_pkg::TVC_SUB_CONTRAST][tvc_pkg::TVC_BIT_D6];
	assign cutoff_r_o = st_reg.regs[tvc_pkg::TVC_SUB_CUT_R];
	assign cutoff_g_o = st_reg.regs[tvc_pkg::TVC_SUB_CUT_G];
	assign cutoff_b_o = st_reg.regs[tvc_pkg::TVC_SUB_CUT_B];
	assign drive_r_o = st_reg.regs[tvc_pkg::TVC_SUB_DRV_R][tvc_pkg::TVC_MSB_7BIT:0];
	assign drive_b_o = st_reg.regs[tvc_pkg::TVC_SUB_DRV_B][tvc_pkg::TVC_MSB_7BIT:0];
	// Carrier pairs 07-D7 with 0B-D3
	assign sound_carrier_o = {st_reg.regs[tvc_pkg::TVC_SUB_DRV_R][tvc_pkg::TVC_BIT_D7],
		st_reg.regs[tvc_pkg::TVC_SUB_VIDEO][tvc_pkg::TVC_BIT_D3]};
	assign chroma_osc_select_o = st_reg.regs[tvc_pkg::TVC_SUB_DRV_B][tvc_pkg::TVC_BIT_D7];
	assign tuning_offset_code_o = st_reg.regs[tvc_pkg::TVC_SUB_TUNE];
	assign tuning_range_stage_o = st_reg.regs[tvc_pkg::TVC_SUB_TRIM][tvc_pkg::TVC_BIT_D7];
	assign tuning_defeat_o = st_reg.tune_defeat;
	assign gain_delay_code_o = st_reg.regs[tvc_pkg::TVC_SUB_GAIN][tvc_pkg::TVC_MSB_6BIT:0];
	// Code 11 is undefined; passed through for the status mux to ignore
	assign status_select_o = {st_reg.regs[tvc_pkg::TVC_SUB_GAIN][tvc_pkg::TVC_BIT_D7],
		st_reg.regs[tvc_pkg::TVC_SUB_GAIN][tvc_pkg::TVC_BIT_D6]};
	assign video_level_o =
		st_reg.regs[tvc_pkg::TVC_SUB_VIDEO][tvc_pkg::TVC_VLEV_MSB:tvc_pkg::TVC_VLEV_LSB];
	assign hpos_o = st_reg.regs[tvc_pkg::TVC_SUB_VIDEO][tvc_pkg::TVC_HPOS_MSB:0];
	assign carrier_osc_trim_code_o =
		st_reg.regs[tvc_pkg::TVC_SUB_TRIM][tvc_pkg::TVC_MSB_7BIT:0];

	// Checks, all in the system clock domain
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	// Write address byte is acknowledged, others skipped
	addr_ack_a: assert property (
		(st_reg.fsm == tvc_pkg::TVC_ADDR && scl_fall && !bus_stop && !bus_start &&
		st_reg.cnt == tvc_pkg::TVC_BYTE_BITS) |=>
		(sda_oe_o == ($past(st_reg.shift) == tvc_pkg::TVC_SLAVE_WR)))
		else $error("address acknowledge wrong");
	// Auto-increment mode advances pointer by one
	ptr_advance_a: assert property (
		(st_reg.fsm == tvc_pkg::TVC_DATA && scl_fall && !bus_stop && !bus_start &&
		st_reg.cnt == tvc_pkg::TVC_BYTE_BITS && st_reg.auto_inc && st_reg.ptr != 4'hf) |=>
		(st_reg.ptr == $past(st_reg.ptr) + 4'h1) ##1 (sda_oe_o || st_reg.fsm != tvc_pkg::TVC_ACK_D))
		else $error("pointer did not advance");
	// Hold mode keeps the pointer
	ptr_hold_a: assert property (
		(st_reg.fsm == tvc_pkg::TVC_DATA && !st_reg.auto_inc) |=> $stable(st_reg.ptr))
		else $error("pointer moved in hold mode");
	// First cycle after reset shows power-on bytes; carrier bits wake at 0
	reset_vals_a: assert property (
		$past(rst_i) |-> (cutoff_r_o == 8'h81 && tuning_range_stage_o &&
		hpos_o == 3'h5 && sound_carrier_o == 2'b00 && carrier_osc_trim_code_o == 7'h41))
		else $error("power-on values wrong");
	// Stored byte appears on outputs after a data byte
	data_store_a: assert property (
		(st_reg.fsm == tvc_pkg::TVC_DATA && scl_fall && !bus_stop && !bus_start &&
		st_reg.cnt == tvc_pkg::TVC_BYTE_BITS && st_reg.ptr == tvc_pkg::TVC_SUB_CUT_G) |=>
		(cutoff_g_o == $past(st_reg.shift)))
		else $error("data byte not stored");
	// Colour off follows a zero saturation code
	colour_kill_a: assert property (
		colour_off_o == (saturation_o == 6'h00))
		else $error("colour off mismatch");
	// Defeat only with stage clear and zero code
	tune_defeat_a: assert property (
		tuning_defeat_o |-> (!tuning_range_stage_o && tuning_offset_code_o == 8'h00))
		else $error("tuning defeat wrongly set");
	// Forced SECAM tracks the high-Z output
	secam_hiz_a: assert property (
		chroma_hiz_o == forced_secam_select_o)
		else $error("high impedance mismatch");
	// 60 Hz force only in manual mode
	vert_force_a: assert property (
		vert_60hz_force_o |-> (vertical_manual_o && vertical_rate_force_o))
		else $error("60 Hz forced outside manual");
	// High subaddresses change no register
	high_addr_a: assert property (
		(st_reg.ptr > tvc_pkg::TVC_SUB_LAST) |=> (st_reg.regs == $past(st_reg.regs)))
		else $error("write beyond 0C took effect");
	// Acknowledge is let go once its clock pulse ends
	ack_release_a: assert property (
		((st_reg.fsm == tvc_pkg::TVC_ACK_A || st_reg.fsm == tvc_pkg::TVC_ACK_S ||
		st_reg.fsm == tvc_pkg::TVC_ACK_D) && scl_fall) |=> !sda_oe_o)
		else $error("acknowledge held too long");
	// Hold mode writes the same register and keeps the pointer
	hold_write_a: assert property (
		(st_reg.fsm == tvc_pkg::TVC_DATA && scl_fall && !st_reg.auto_inc &&
		st_reg.cnt == tvc_pkg::TVC_BYTE_BITS && st_reg.ptr == tvc_pkg::TVC_SUB_CUT_G) |=>
		(cutoff_g_o == $past(st_reg.shift) && st_reg.ptr == tvc_pkg::TVC_SUB_CUT_G))
		else $error("hold mode write wrong");
	// A subaddress with an unknown mode nibble is refused
	sub_refuse_a: assert property (
		(st_reg.fsm == tvc_pkg::TVC_SUB && scl_fall &&
		st_reg.cnt == tvc_pkg::TVC_BYTE_BITS &&
		st_reg.shift[7:4] != tvc_pkg::TVC_MODE_INC &&
		st_reg.shift[7:4] != tvc_pkg::TVC_MODE_HOLD) |=>
		(!sda_oe_o && st_reg.fsm == tvc_pkg::TVC_SKIP))
		else $error("bad subaddress mode accepted");
	// Registers move only when an accepted data byte completes
	regs_quiet_a: assert property (
		!(st_reg.fsm == tvc_pkg::TVC_DATA && scl_fall &&
		st_reg.cnt == tvc_pkg::TVC_BYTE_BITS) |=> $stable(st_reg.regs))
		else $error("register changed without a data byte");
	// Refused or idle bus never sees the data line pulled
	skip_silent_a: assert property (
		(st_reg.fsm == tvc_pkg::TVC_SKIP || st_reg.fsm == tvc_pkg::TVC_IDLE) |-> !sda_oe_o)
		else $error("acknowledge outside a transfer");
	// Mode switches wake in their power-on positions
	reset_modes_a: assert property (
		$past(rst_i) |-> (sound_route_o == 2'b00 && status_select_o == 2'b00 &&
		!video_input_select_o && !colour_std_o && !vertical_manual_o && !sda_oe_o))
		else $error("power-on modes wrong");
	// Stage clear with a zero code must defeat
	defeat_set_a: assert property (
		(!tuning_range_stage_o && tuning_offset_code_o == 8'h00) |-> tuning_defeat_o)
		else $error("tuning defeat missing");
	// Manual mode with the rate bit set forces 60 Hz
	vert_manual_a: assert property (
		(vertical_manual_o && vertical_rate_force_o) |-> vert_60hz_force_o)
		else $error("60 Hz force missing in manual");
	// Bytes past the last register are acknowledged and dropped
	high_ack_a: assert property (
		(st_reg.fsm == tvc_pkg::TVC_DATA && scl_fall &&
		st_reg.cnt == tvc_pkg::TVC_BYTE_BITS && st_reg.ptr > tvc_pkg::TVC_SUB_LAST) |=>
		(sda_oe_o && st_reg.regs == $past(st_reg.regs)))
		else $error("byte past last register mishandled");

endmodule

// ==== src/tvc_pkg.sv ====
// Constants and types shared by the television processor control bank.
package tvc_pkg;
	// Serial bus write address of this device
	localparam logic [7:0] TVC_SLAVE_WR = 8'h8a;
	// Subaddress upper nibble modes
	localparam logic [3:0] TVC_MODE_INC = 4'h0;
	localparam logic [3:0] TVC_MODE_HOLD = 4'h8;
	// Register offsets (subaddresses)
	localparam logic [3:0] TVC_SUB_COLOUR = 4'h0;
	localparam logic [3:0] TVC_SUB_TINT = 4'h1;
	localparam logic [3:0] TVC_SUB_BRIGHT = 4'h2;
	localparam logic [3:0] TVC_SUB_CONTRAST = 4'h3;
	localparam logic [3:0] TVC_SUB_CUT_R = 4'h4;
	localparam logic [3:0] TVC_SUB_CUT_G = 4'h5;
	localparam logic [3:0] TVC_SUB_CUT_B = 4'h6;
	localparam logic [3:0] TVC_SUB_DRV_R = 4'h7;
	localparam logic [3:0] TVC_SUB_DRV_B = 4'h8;
	localparam logic [3:0] TVC_SUB_TUNE = 4'h9;
	localparam logic [3:0] TVC_SUB_GAIN = 4'ha;
	localparam logic [3:0] TVC_SUB_VIDEO = 4'hb;
	localparam logic [3:0] TVC_SUB_TRIM = 4'hc;
	localparam logic [3:0] TVC_SUB_LAST = 4'hc;
	localparam int TVC_NREG = 13;
	// Power-on values, index 12 down to 0
	localparam logic [12:0][7:0] TVC_RESET = {
		8'hc1, 8'h45, 8'h21, 8'h01, 8'h41, 8'h41, 8'h81,
		8'h81, 8'h81, 8'h21, 8'h41, 8'h21, 8'h21};
	// Single-bit field positions
	localparam int TVC_BIT_D7 = 7;
	localparam int TVC_BIT_D6 = 6;
	localparam int TVC_BIT_D3 = 3;
	// Multi-bit field extents (msb positions, lsb is 0 unless named)
	localparam int TVC_MSB_6BIT = 5;
	localparam int TVC_MSB_7BIT = 6;
	localparam int TVC_VLEV_MSB = 6;
	localparam int TVC_VLEV_LSB = 4;
	localparam int TVC_HPOS_MSB = 2;
	// Bits per serial byte
	localparam logic [3:0] TVC_BYTE_BITS = 4'h8;
	// Serial engine states, Gray coded along the write path
	typedef enum logic [2:0] {
		TVC_IDLE = 3'h0,
		TVC_ADDR = 3'h1,
		TVC_ACK_A = 3'h3,
		TVC_SUB = 3'h2,
		TVC_ACK_S = 3'h6,
		TVC_DATA = 3'h7,
		TVC_ACK_D = 3'h5,
		TVC_SKIP = 3'h4
	} tvc_fsm_t;
	// Whole module state
	typedef struct packed {
		logic scl_q;
		logic sda_q;
		tvc_fsm_t fsm;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic [3:0] ptr;
		logic auto_inc;
		logic sda_oe;
		logic sda_out;
		logic [12:0][7:0] regs;
		logic colour_off;
		logic chroma_hiz;
		logic tune_defeat;
		logic vert_60hz;
	} tvc_state_t;
endpackage

// ==== dv/tvc_host_model.sv ====
// Serial bus master model that writes the control bank.
`timescale 1ns/1ps
module tvc_host_model (
	input wire logic sys_clk_i, // Bench clock
	input wire logic sda_i, // Resolved data line
	output logic scl_o, // Serial clock, idle high
	output logic sda_oe_o // High while pulling data low
);
	// Bus idle from time zero
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// Four cycles per level, four times the one-cycle floor the engine needs
	task automatic half();
		repeat (4) @(negedge sys_clk_i);
	endtask
	// Data falls while clock high
	task automatic start();
		sda_oe_o = 1'b1;
		half();
		scl_o = 1'b0;
		half();
	endtask
	// Data moves only a level after the clock fell, never with it
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_oe_o = ~b[i];
			half();
			scl_o = 1'b1;
			half();
			scl_o = 1'b0;
			half();
		end
		sda_oe_o = 1'b0;
		half();
		scl_o = 1'b1;
		half();
		ack = ~sda_i;
		scl_o = 1'b0;
		half();
	endtask
	// Data rises while clock high
	task automatic stop();
		sda_oe_o = 1'b1;
		half();
		scl_o = 1'b1;
		half();
		sda_oe_o = 1'b0;
		half();
	endtask
	// Whole framed write; acks holds address, subaddress, all data
	task automatic write(input logic [7:0] adr, input logic [7:0] sub,
			input logic [7:0] d [$], output logic [2:0] acks);
		logic a;
		start();
		send(adr, a);
		acks[0] = a;
		send(sub, a);
		acks[1] = a;
		acks[2] = 1'b1;
		foreach (d[i]) begin
			send(d[i], a);
			acks[2] &= a;
		end
		stop();
	endtask
endmodule

// ==== dv/tvc_ctrl_regs_tb.sv ====
// Self-checking bench for the control bank driven by the host model.
`timescale 1ns/1ps
module tvc_ctrl_regs_tb;
	logic sys_clk, rst, scl, sda_dev, oe_dev, oe_host, sda;
	logic cstd, secam, hiz, coff, vman, vtrig, vrate, v60, vsel, chosc, stage, defeat;
	logic [5:0] sat, tint, contrast, gain;
	logic [6:0] bright, drv_r, drv_b, trim;
	logic [7:0] cut_r, cut_g, cut_b, tune;
	logic [1:0] route, carrier, status;
	logic [2:0] vlev, hpos;
	logic [2:0] acks;
	logic [7:0] q [$];
	int fails, checked, seed;
	int mreg [13]; // Reference copy of the bank
	// Open-drain line with pull-up
	assign sda = ~(oe_host | (oe_dev & ~sda_dev));
	tvc_ctrl_regs DUT (.sys_clk_i(sys_clk), .rst_i(rst), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_dev), .sda_oe_o(oe_dev), .colour_std_o(cstd), .forced_secam_select_o(secam),
		.chroma_hiz_o(hiz), .saturation_o(sat), .colour_off_o(coff), .tint_o(tint),
		.vertical_manual_o(vman), .vertical_trigger_inhibit_o(vtrig), .brightness_o(bright),
		.vertical_rate_force_o(vrate), .vert_60hz_force_o(v60), .contrast_o(contrast),
		.sound_route_o(route), .video_input_select_o(vsel), .cutoff_r_o(cut_r),
		.cutoff_g_o(cut_g), .cutoff_b_o(cut_b), .drive_r_o(drv_r), .drive_b_o(drv_b),
		.sound_carrier_o(carrier), .chroma_osc_select_o(chosc), .tuning_offset_code_o(tune),
		.tuning_range_stage_o(stage), .tuning_defeat_o(defeat), .gain_delay_code_o(gain),
		.status_select_o(status), .video_level_o(vlev), .hpos_o(hpos),
		.carrier_osc_trim_code_o(trim));
	tvc_host_model host (.sys_clk_i(sys_clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(oe_host));
	// 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// One comparison, counted
	task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", name, e, g);
		end
	endtask
	// Every decoded output against the reference copy
	task automatic check_all();
		logic [7:0] r [13];
		foreach (r[i]) r[i] = mreg[i][7:0];
		chk("colour_std", 8'(r[0][7]), 8'(cstd));
		chk("secam", 8'(r[0][6]), 8'(secam));
		chk("hiz", 8'(r[0][6]), 8'(hiz));
		chk("sat", 8'(r[0][5:0]), 8'(sat));
		chk("colour_off", 8'(r[0][5:0] == 6'h00), 8'(coff));
		chk("tint", 8'(r[1][5:0]), 8'(tint));
		chk("vman", 8'(r[1][7]), 8'(vman));
		chk("vtrig", 8'(r[1][6]), 8'(vtrig));
		chk("bright", 8'(r[2][6:0]), 8'(bright));
		chk("vrate", 8'(r[2][7]), 8'(vrate));
		chk("v60", 8'(r[1][7] & r[2][7]), 8'(v60));
		chk("contrast", 8'(r[3][5:0]), 8'(contrast));
		chk("route", 8'({r[3][7], r[11][7]}), 8'(route));
		chk("vsel", 8'(r[3][6]), 8'(vsel));
		chk("cut_r", r[4], cut_r);
		chk("cut_g", r[5], cut_g);
		chk("cut_b", r[6], cut_b);
		chk("drv_r", 8'(r[7][6:0]), 8'(drv_r));
		chk("drv_b", 8'(r[8][6:0]), 8'(drv_b));
		chk("carrier", 8'({r[7][7], r[11][3]}), 8'(carrier));
		chk("chosc", 8'(r[8][7]), 8'(chosc));
		chk("tune", r[9], tune);
		chk("stage", 8'(r[12][7]), 8'(stage));
		chk("defeat", 8'(!r[12][7] && r[9] == 8'h00), 8'(defeat));
		chk("gain", 8'(r[10][5:0]), 8'(gain));
		chk("status", 8'(r[10][7:6]), 8'(status));
		chk("vlev", 8'(r[11][6:4]), 8'(vlev));
		chk("hpos", 8'(r[11][2:0]), 8'(hpos));
		chk("trim", 8'(r[12][6:0]), 8'(trim));
	endtask
	// Send q, update the reference, compare acks and outputs
	task automatic xfer(input logic [7:0] adr, input logic [7:0] sub);
		logic ok;
		int p;
		ok = adr == 8'h8a && (sub[7:4] == 4'h0 || sub[7:4] == 4'h8);
		host.write(adr, sub, q, acks);
		chk("ack_addr", 8'(adr == 8'h8a), 8'(acks[0]));
		chk("ack_sub", 8'(ok), 8'(acks[1]));
		chk("ack_data", 8'(ok || q.size() == 0), 8'(acks[2]));
		p = int'(sub[3:0]);
		foreach (q[i]) begin
			if (ok && p <= 12) mreg[p] = q[i];
			if (sub[7:4] == 4'h0 && p < 15) p++;
		end
		check_all();
	endtask
	// Verdict, from the main sequence or the watchdog
	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Watchdog: run needs about 20k cycles, so 80k means a hang
	initial begin
		#800000;
		fails++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		seed = 13868;
		fails = 0;
		checked = 0;
		mreg = '{'h21, 'h21, 'h41, 'h21, 'h81, 'h81, 'h81, 'h41, 'h41, 'h01, 'h21, 'h45, 'hc1};
		rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		repeat (2) @(negedge sys_clk);
		check_all();
		$display("Test reset done");
		// Sweep from 00 running past the last register
		q = {};
		repeat (15) q.push_back(8'($random(seed)));
		xfer(8'h8a, 8'h00);
		q = {8'h11, 8'h22, 8'h33};
		xfer(8'h8a, 8'h85);
		$display("Test pointer modes done");
		// Read address, foreign address, bad nibble, high subaddress
		q = {8'h00, 8'h55};
		xfer(8'h8b, 8'h01);
		xfer(8'h8c, 8'h01);
		xfer(8'h8a, 8'h41);
		xfer(8'h8a, 8'h0d);
		$display("Test refusals done");
		// Boundary codes: saturation zero, extremes, defeat on and off
		q = {8'h80, 8'hff, 8'hff, 8'h7f};
		xfer(8'h8a, 8'h00);
		q = {8'h00};
		xfer(8'h8a, 8'h0c);
		xfer(8'h8a, 8'h89);
		q = {8'h80};
		xfer(8'h8a, 8'h0c);
		$display("Test boundaries done");
		// Every two-bit code of status, route and carrier
		for (int k = 0; k < 4; k++) begin
			q = {8'(k * 64)};
			xfer(8'h8a, 8'h8a);
			xfer(8'h8a, 8'h83);
			xfer(8'h8a, 8'h87);
			q = {8'((k % 2) * 136)};
			xfer(8'h8a, 8'h8b);
		end
		$display("Test mode codes done");
		// Random bursts in both pointer modes
		for (int n = 0; n < 12; n++) begin
			q = {};
			repeat (1 + $unsigned($random(seed)) % 4) q.push_back(8'($random(seed)));
			xfer(8'h8a, {n[0], 3'h0, 4'($unsigned($random(seed)) % 13)});
		end
		$display("Test random done");
		tally_and_finish();
	end
endmodule
